// [hw/urft_defines.svh]
`ifndef URFT_DEFINES_SVH
`define URFT_DEFINES_SVH

// Register byte offsets on the APB bus.
`define URFT_OFS_CTRL 12'h000
`define URFT_OFS_IEN 12'h004
`define URFT_OFS_ISTAT 12'h008
`define URFT_OFS_FRAME 12'h00c
`define URFT_OFS_DADDR 12'h010
`define URFT_OFS_EPCSR 12'h014
`define URFT_OFS_EPIST 12'h018
`define URFT_OFS_EPTCR 12'h01c
`define URFT_OFS_EPCFG 12'h020
`define URFT_OFS_EPIEN 12'h024

// Interrupt status and enable bit positions.
`define URFT_BIT_SOF 1
`define URFT_BIT_URST 2
`define URFT_BIT_SUSP 4
`define URFT_BIT_ESOF 5

// Frame tracking field positions.
`define URFT_HOST_FRAME_NUMBER_MSB 10
`define URFT_LOCK_BIT 16
`define URFT_MISSED_FRAME_COUNT_LSB 17
`define URFT_MISSED_FRAME_COUNT_MSB 18

// Reset values.
`define URFT_EPCSR_RST 32'h0000_0002
`define URFT_ZERO_RST 32'h0000_0000

// Frame period of 1 ms, counted in 100 ns cycles.
`define URFT_FRAME_US 1000
`define URFT_CLK_NS 100
`define URFT_FRAME_CYC ((`URFT_FRAME_US * 1000) / `URFT_CLK_NS)
`define URFT_ESOF_LIMIT 3

`endif

// [hw/urft_pkg.sv]
package urft_pkg;

  typedef enum logic [1:0] {
    URFT_PS_IDLE = 2'b00,
    URFT_PS_ACTIVE = 2'b01,
    URFT_PS_HALT = 2'b10
  } urft_pstate_type;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] ien;
    logic bus_reset_flag;
    logic frame_start_flag;
    logic missed_frame_flag;
    logic suspend_flag;
    logic [1:0] missed_frame_count;
    logic [1:0] esof_run;
    logic frame_lock_flag;
    logic [10:0] host_frame_number;
    logic [6:0] device_address_field;
    logic [31:0] epcsr;
    logic [31:0] epist;
    logic [31:0] eptcr;
    logic [31:0] epcfg;
    logic [31:0] epien;
    logic [13:0] frame_timer;
    urft_pstate_type pstate;
    logic [2:0] rst_sync;
    logic rst_seen;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic traffic_en;
  } urft_state_type;

endpackage : urft_pkg

// [hw/urft_top.sv]
// Behaviour
// - Bus reset detection sets bus reset flag.
// - Bus reset restarts protocol state; enable-gated interrupt.
// - Traffic blocked while bus reset flag set.
// - Global registers survive a bus reset.
// - Endpoint status, interrupt, count registers reset.
// - Endpoint configuration and enables survive reset.
// - Writing one clears reset, frame-start flags.
// - Received start-of-frame sets frame-start flag.
// - Missed-frame flag set increments missed count.
// - Received start-of-frame clears missed count.
// - Start-of-frame before timer expiry sets lock.
// - While locked, capture received frame number.
// - No start-of-frame within 1 ms clears lock.
// - Writable seven-bit address field, resets zero.
// - Bus reset clears the device address.
// - Missed frame sets flag; enable-gated interrupt.
// - Three consecutive misses set suspend flag.
`timescale 1ns/1ps
`include "urft_defines.svh"

module urft_top #(
  parameter int FRAME_CYCLES = `URFT_FRAME_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link events from the packet engine, on pclk.
  input wire logic usb_reset_pin,
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame_number,
  // Outputs to the rest of the controller.
  output logic irq,
  output logic traffic_en,
  output logic [6:0] device_address,
  output logic [1:0] protocol_state
);

  if (FRAME_CYCLES < 2 || FRAME_CYCLES > 16383) begin : g_bad_frame_cycles
    $error("FRAME_CYCLES out of range");
  end

  urft_pkg::urft_state_type s_r;
  urft_pkg::urft_state_type s_nxt;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  logic wr_en;
  logic rd_en;
  logic bus_rst_evt;
  logic frame_expire;
  logic esof_evt;
  logic [31:0] istat;
  logic [31:0] frame_reg;

  assign wr_en = psel && penable && pwrite && !s_r.pready;
  assign rd_en = psel && penable && !pwrite && !s_r.pready;
  assign bus_rst_evt = s_r.rst_sync[1] && !s_r.rst_seen;
  assign frame_expire = (s_r.frame_timer == 14'(FRAME_CYCLES - 1));
  assign esof_evt = frame_expire && !sof_valid;

  always_comb begin
    istat = 32'h0000_0000;
    istat[`URFT_BIT_SOF] = s_r.frame_start_flag;
    istat[`URFT_BIT_URST] = s_r.bus_reset_flag;
    istat[`URFT_BIT_SUSP] = s_r.suspend_flag;
    istat[`URFT_BIT_ESOF] = s_r.missed_frame_flag;
    frame_reg = 32'h0000_0000;
    frame_reg[`URFT_HOST_FRAME_NUMBER_MSB:0] = s_r.host_frame_number;
    frame_reg[`URFT_LOCK_BIT] = s_r.frame_lock_flag;
    frame_reg[`URFT_MISSED_FRAME_COUNT_MSB:`URFT_MISSED_FRAME_COUNT_LSB] = s_r.missed_frame_count;
  end

  always_comb begin
    s_nxt = s_r;
    // The pin is asynchronous, so it passes two flip-flops first.
    s_nxt.rst_sync = {s_r.rst_sync[1:0], usb_reset_pin};
    s_nxt.rst_seen = s_r.rst_sync[1];
    // One-wait answer: pready rises for one cycle, in the second cycle of the access phase.
    s_nxt.pready = psel && penable && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0000_0000;

    if (sof_valid) begin
      s_nxt.frame_timer = 14'h0000;
    end else if (frame_expire) begin
      s_nxt.frame_timer = 14'h0000;
    end else begin
      s_nxt.frame_timer = s_r.frame_timer + 14'h0001;
    end

    // Software side: writes first, so hardware events below win.
    if (wr_en) begin
      unique case (paddr)
        `URFT_OFS_CTRL: s_nxt.ctrl = pwdata;
        `URFT_OFS_IEN: s_nxt.ien = pwdata;
        `URFT_OFS_ISTAT: begin
          if (pwdata[`URFT_BIT_URST]) s_nxt.bus_reset_flag = 1'b0;
          if (pwdata[`URFT_BIT_SOF]) s_nxt.frame_start_flag = 1'b0;
          if (pwdata[`URFT_BIT_SUSP]) s_nxt.suspend_flag = 1'b0;
          // Missed-frame flag only accepts a written zero.
          if (!pwdata[`URFT_BIT_ESOF]) s_nxt.missed_frame_flag = 1'b0;
        end
        `URFT_OFS_DADDR: s_nxt.device_address_field = pwdata[6:0];
        `URFT_OFS_EPCSR: s_nxt.epcsr = pwdata;
        `URFT_OFS_EPIST: s_nxt.epist = s_r.epist & ~pwdata;
        `URFT_OFS_EPTCR: s_nxt.eptcr = pwdata;
        `URFT_OFS_EPCFG: s_nxt.epcfg = pwdata;
        `URFT_OFS_EPIEN: s_nxt.epien = pwdata;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end else if (rd_en) begin
      unique case (paddr)
        `URFT_OFS_CTRL: s_nxt.prdata = s_r.ctrl;
        `URFT_OFS_IEN: s_nxt.prdata = s_r.ien;
        `URFT_OFS_ISTAT: s_nxt.prdata = istat;
        `URFT_OFS_FRAME: s_nxt.prdata = frame_reg;
        `URFT_OFS_DADDR: s_nxt.prdata = {25'h0, s_r.device_address_field};
        `URFT_OFS_EPCSR: s_nxt.prdata = s_r.epcsr;
        `URFT_OFS_EPIST: s_nxt.prdata = s_r.epist;
        `URFT_OFS_EPTCR: s_nxt.prdata = s_r.eptcr;
        `URFT_OFS_EPCFG: s_nxt.prdata = s_r.epcfg;
        `URFT_OFS_EPIEN: s_nxt.prdata = s_r.epien;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end

    if (sof_valid) begin
      s_nxt.frame_start_flag = 1'b1;
      s_nxt.missed_frame_count = 2'b00;
      s_nxt.esof_run = 2'b00;
      if (!frame_expire) s_nxt.frame_lock_flag = 1'b1;
      if (s_r.frame_lock_flag) begin
        s_nxt.host_frame_number = sof_frame_number;
      end
      if (s_r.pstate == urft_pkg::URFT_PS_IDLE) begin
        s_nxt.pstate = urft_pkg::URFT_PS_ACTIVE;
      end
    end else if (esof_evt) begin
      s_nxt.frame_lock_flag = 1'b0;
      s_nxt.missed_frame_flag = 1'b1;
      // The two-bit count rolls over rather than saturating.
      s_nxt.missed_frame_count = s_r.missed_frame_count + 2'b01;
      if (s_r.esof_run == 2'(`URFT_ESOF_LIMIT - 1)) begin
        s_nxt.suspend_flag = 1'b1;
        s_nxt.esof_run = 2'b00;
      end else begin
        s_nxt.esof_run = s_r.esof_run + 2'b01;
      end
    end

    // Global, enable and frame registers are left alone here.
    if (bus_rst_evt) begin
      s_nxt.bus_reset_flag = 1'b1;
      s_nxt.pstate = urft_pkg::URFT_PS_IDLE;
      s_nxt.epcsr = `URFT_EPCSR_RST;
      s_nxt.epist = `URFT_ZERO_RST;
      s_nxt.eptcr = `URFT_ZERO_RST;
      s_nxt.device_address_field = 7'h00;
    end

    // Traffic stays off until software has acknowledged the reset.
    s_nxt.traffic_en = !s_nxt.bus_reset_flag;
    s_nxt.irq = (s_r.ien[`URFT_BIT_URST] && s_r.bus_reset_flag) ||
      (s_r.ien[`URFT_BIT_ESOF] && s_r.missed_frame_flag) ||
      (s_r.ien[`URFT_BIT_SOF] && s_r.frame_start_flag) ||
      (s_r.ien[`URFT_BIT_SUSP] && s_r.suspend_flag);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.epcsr <= `URFT_EPCSR_RST;
      s_r.pstate <= urft_pkg::URFT_PS_IDLE;
      s_r.traffic_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;
  assign traffic_en = s_r.traffic_en;
  assign device_address = s_r.device_address_field;
  assign protocol_state = s_r.pstate;

  a_reset_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt |=> s_r.bus_reset_flag)
    else $error("bus reset flag not set");

  a_reset_state: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt |=> protocol_state == urft_pkg::URFT_PS_IDLE)
    else $error("protocol state not restarted");

  a_irq_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_r.ien == 32'h0000_0000 |=> !irq)
    else $error("interrupt raised with all enables off");

  a_reset_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_r.ien[`URFT_BIT_URST] && s_r.bus_reset_flag |=> irq)
    else $error("enabled bus reset gave no interrupt");

  // Same cycle on purpose: a clear and the re-enable land on one edge.
  a_traffic_block: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_r.bus_reset_flag |-> !traffic_en)
    else $error("traffic enabled during bus reset");

  a_ien_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt && !wr_en |=> $stable(s_r.ien))
    else $error("enable register changed by bus reset");

  a_ctrl_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt && !wr_en |=> $stable(s_r.ctrl))
    else $error("control register changed by bus reset");

  a_frame_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt && !sof_valid && !esof_evt |=>
      $stable(s_r.host_frame_number) && $stable(s_r.missed_frame_count))
    else $error("frame register changed by bus reset");

  a_ep_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt |=> s_r.epcsr == `URFT_EPCSR_RST &&
      s_r.epist == `URFT_ZERO_RST && s_r.eptcr == `URFT_ZERO_RST)
    else $error("endpoint registers not reset");

  a_epcfg_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt && !wr_en |=> $stable(s_r.epcfg) && $stable(s_r.epien))
    else $error("endpoint config changed by bus reset");

  a_w1c_sof: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `URFT_OFS_ISTAT) && pwdata[`URFT_BIT_SOF] &&
      !sof_valid |=> !s_r.frame_start_flag)
    else $error("frame start flag not cleared");

  a_w1c_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `URFT_OFS_ISTAT) && pwdata[`URFT_BIT_URST] &&
      !bus_rst_evt |=> !s_r.bus_reset_flag)
    else $error("bus reset flag not cleared");

  a_w0_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `URFT_OFS_ISTAT) && !pwdata[`URFT_BIT_URST] &&
      s_r.bus_reset_flag |=> s_r.bus_reset_flag)
    else $error("bus reset flag lost on a written zero");

  a_sof_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    sof_valid |=> s_r.frame_start_flag && s_r.missed_frame_count == 2'h0)
    else $error("start of frame not recorded");

  a_miss_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    esof_evt |=> s_r.missed_frame_count ==
      2'($past(s_r.missed_frame_count) + 1))
    else $error("missed count not incremented");

  a_miss_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    esof_evt && s_r.missed_frame_count == 2'h3 |=>
      s_r.missed_frame_count == 2'h0)
    else $error("missed count did not wrap");

  a_lock_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    sof_valid && !frame_expire |=> s_r.frame_lock_flag)
    else $error("lock not set on timely start of frame");

  a_host_frame_number_load: assert property (
    @(posedge pclk) disable iff (!presetn)
    sof_valid && s_r.frame_lock_flag
    |=> s_r.host_frame_number == $past(sof_frame_number))
    else $error("frame number not captured");

  a_lock_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    esof_evt |=> !s_r.frame_lock_flag && s_r.missed_frame_flag)
    else $error("lock not dropped on missed frame");

  a_addr_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `URFT_OFS_DADDR) && !bus_rst_evt |=>
      device_address == $past(pwdata[6:0]))
    else $error("address write not taken");

  a_addr_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_rst_evt |=> device_address == 7'h00)
    else $error("address not cleared on bus reset");

  a_miss_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_r.ien[`URFT_BIT_ESOF] && s_r.missed_frame_flag |=> irq)
    else $error("enabled missed frame gave no interrupt");

  a_suspend_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    esof_evt && s_r.esof_run == 2'h2 |=> s_r.suspend_flag)
    else $error("suspend flag not set on third miss");

endmodule : urft_top

// [sim/tb.sv]
`timescale 1ns/1ps
`include "urft_defines.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic usb_reset_pin;
  logic sof_valid;
  logic [10:0] sof_frame_number;
  logic irq;
  logic traffic_en;
  logic [6:0] device_address;
  logic [1:0] protocol_state;
  int errors = 0;
  int n_compared = 0;
  int seed = 32'h9d9d;
  logic [31:0] r, w, v1, v2;
  logic err;
  logic [10:0] fa, fb;

  always #50 pclk = ~pclk;

  urft_top #(.FRAME_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_reset_pin(usb_reset_pin), .sof_valid(sof_valid),
    .sof_frame_number(sof_frame_number), .irq(irq),
    .traffic_en(traffic_en), .device_address(device_address),
    .protocol_state(protocol_state));

  urft_host_model host (.pclk(pclk), .usb_reset_pin(usb_reset_pin),
    .sof_valid(sof_valid), .sof_frame_number(sof_frame_number));

  task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    if (n >= 50) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // The whole run is a few hundred cycles; this allows about fifteen times that.
  initial begin
    #400000;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`URFT_OFS_DADDR);
    chk(r, 32'h0);
    rd(`URFT_OFS_EPCSR);
    chk(r, `URFT_EPCSR_RST);
    rd(12'h028);
    chk({31'h0, err}, 32'h1);
    repeat (3) begin
      w = $random(seed);
      wr(`URFT_OFS_DADDR, w);
      rd(`URFT_OFS_DADDR);
      chk(r, {25'h0, w[6:0]});
      chk({25'h0, device_address}, {25'h0, w[6:0]});
    end
    $display("test address done");
    fa = 11'($random(seed));
    fb = 11'($random(seed));
    host.send_sof(fa);
    host.send_sof(fb);
    rd(`URFT_OFS_FRAME);
    chk(r, 32'h1_0000 | {21'h0, fb});
    rd(`URFT_OFS_ISTAT);
    chk(r & 32'h2, 32'h2);
    wr(`URFT_OFS_ISTAT, 32'h0);
    rd(`URFT_OFS_ISTAT);
    chk(r & 32'h2, 32'h2);
    wr(`URFT_OFS_ISTAT, 32'h2);
    rd(`URFT_OFS_ISTAT);
    chk(r & 32'h2, 32'h0);
    host.send_sof(fa);
    repeat (30) @(posedge pclk);
    rd(`URFT_OFS_FRAME);
    chk(r & 32'h7_0000, 32'h2_0000);
    rd(`URFT_OFS_ISTAT);
    chk(r & 32'h20, 32'h20);
    wr(`URFT_OFS_IEN, 32'h20);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`URFT_OFS_IEN, 32'h0);
    repeat (21) @(posedge pclk);
    rd(`URFT_OFS_FRAME);
    chk(r & 32'h6_0000, 32'h6_0000);
    rd(`URFT_OFS_ISTAT);
    chk(r & 32'h10, 32'h10);
    repeat (8) @(posedge pclk);
    rd(`URFT_OFS_FRAME);
    chk(r & 32'h6_0000, 32'h0);
    $display("test frame done");
    wr(`URFT_OFS_IEN, 32'h0);
    host.bus_reset(6);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`URFT_OFS_ISTAT, 32'h4);
    wr(`URFT_OFS_IEN, 32'h4);
    wr(`URFT_OFS_DADDR, 32'h7f);
    wr(`URFT_OFS_EPTCR, $random(seed) | 32'h1);
    wr(`URFT_OFS_EPCFG, $random(seed));
    rd(`URFT_OFS_EPCFG);
    v1 = r;
    wr(`URFT_OFS_EPIEN, $random(seed));
    rd(`URFT_OFS_EPIEN);
    v2 = r;
    w = $random(seed);
    wr(`URFT_OFS_CTRL, w);
    wr(`URFT_OFS_EPCSR, $random(seed) | 32'h1);
    host.send_sof(fa);
    host.bus_reset(6);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, traffic_en}, 32'h0);
    chk({25'h0, device_address}, 32'h0);
    chk({30'h0, protocol_state}, {30'h0, urft_pkg::URFT_PS_IDLE});
    wr(`URFT_OFS_ISTAT, 32'h0);
    rd(`URFT_OFS_ISTAT);
    chk(r & 32'h4, 32'h4);
    rd(`URFT_OFS_CTRL);
    chk(r, w);
    rd(`URFT_OFS_IEN);
    chk(r, 32'h4);
    rd(`URFT_OFS_EPCSR);
    chk(r, `URFT_EPCSR_RST);
    rd(`URFT_OFS_EPTCR);
    chk(r, 32'h0);
    rd(`URFT_OFS_EPCFG);
    chk(r, v1);
    rd(`URFT_OFS_EPIEN);
    chk(r, v2);
    wr(`URFT_OFS_ISTAT, 32'h4);
    repeat (3) @(negedge pclk);
    chk({31'h0, traffic_en}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test bus reset done");
    give_verdict();
  end
endmodule : tb

// [sim/urft_host_model.sv]
`timescale 1ns/1ps
// Host end of the link, as the packet engine reports it on pclk.
module urft_host_model (
  // Clock.
  input wire logic pclk,
  // Link events.
  output logic usb_reset_pin,
  output logic sof_valid,
  output logic [10:0] sof_frame_number
);
  initial begin
    usb_reset_pin = 1'b0;
    sof_valid = 1'b0;
    sof_frame_number = 11'h000;
  end

  // The number is inverted after the pulse so a stale value is never reused.
  task send_sof(input logic [10:0] n);
    @(posedge pclk);
    sof_valid <= 1'b1;
    sof_frame_number <= n;
    @(posedge pclk);
    sof_valid <= 1'b0;
    sof_frame_number <= ~n;
  endtask : send_sof

  task bus_reset(input int cyc);
    @(posedge pclk);
    usb_reset_pin <= 1'b1;
    repeat (cyc) @(posedge pclk);
    usb_reset_pin <= 1'b0;
  endtask : bus_reset
endmodule : urft_host_model
